// file: pkg/nv_access_pkg.sv
package nv_access_pkg;
    localparam logic [5:0] ADDR_OFS       = 6'h1e;
    localparam logic [5:0] DATA_OFS       = 6'h1d;
    localparam logic [5:0] CTRL_OFS       = 6'h1c;
    localparam int         READY_IE_BIT   = 3;
    localparam int         ARM_BIT        = 2;
    localparam int         STROBE_BIT     = 1;
    localparam int         READ_BIT       = 0;
    localparam logic [1:0] ARM_CYCLES     = 2'h3;
    localparam int         WRITE_RC_CYCLES = 8192;
    localparam logic [2:0] WRITE_STALL    = 3'h2;
    localparam logic [2:0] READ_STALL     = 3'h4;
    localparam int         NV_DEPTH       = 64;
endpackage : nv_access_pkg

// file: hw/eeprom_byte_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_access_control (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clk_en_i,
    input  wire logic       rc_tick_i,
    input  wire logic       global_irq_en_i,
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    output logic            cpu_stall_o,
    output logic            ready_irq_o
);
    logic [7:0]  mem [0:nv_access_pkg::NV_DEPTH-1];
    logic [5:0]  addr_reg;
    logic [7:0]  data_reg;
    logic        ready_ie_reg;
    logic        arm_reg;
    logic        busy_reg;
    logic [1:0]  arm_cnt_reg;
    logic [12:0] rc_cnt_reg;
    logic [2:0]  stall_reg;
    logic [7:0]  rdata_reg;

    wire wr_addr = io_wr_i && io_addr_i == nv_access_pkg::ADDR_OFS;
    wire wr_data = io_wr_i && io_addr_i == nv_access_pkg::DATA_OFS;
    wire wr_ctrl = io_wr_i && io_addr_i == nv_access_pkg::CTRL_OFS;
    wire rd_go   = wr_ctrl && io_wdata_i[nv_access_pkg::READ_BIT] && !busy_reg;
    wire wr_go   = wr_ctrl && io_wdata_i[nv_access_pkg::STROBE_BIT] && arm_reg && !busy_reg;
    wire arm_set = wr_ctrl && io_wdata_i[nv_access_pkg::ARM_BIT];
    wire abort   = busy_reg && (wr_addr || wr_data);
    // gated by busy: the count rests at its end value once a write has finished
    wire rc_last = busy_reg && rc_tick_i &&
                   rc_cnt_reg == 13'(nv_access_pkg::WRITE_RC_CYCLES - 1);
    wire [7:0] ctrl_view = {4'h0, ready_ie_reg, arm_reg, busy_reg, 1'b0};
    wire [7:0] rd_mux =
        io_addr_i == nv_access_pkg::ADDR_OFS ? {2'b00, addr_reg} :
        io_addr_i == nv_access_pkg::DATA_OFS ? data_reg :
        io_addr_i == nv_access_pkg::CTRL_OFS ? ctrl_view : 8'h00;

    assign io_rdata_o  = rdata_reg;
    assign cpu_stall_o = stall_reg != 3'h0;
    assign ready_irq_o = ready_ie_reg && global_irq_en_i && !busy_reg;

    // address reg left unreset: software must load it first
    always_ff @(posedge mclk_i) begin
        if (clk_en_i && wr_addr) begin
            addr_reg <= io_wdata_i[5:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (clk_en_i && wr_go) begin
            mem[addr_reg] <= data_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            data_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_go) begin
                data_reg <= mem[addr_reg];
            end else if (wr_data) begin
                data_reg <= io_wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ready_ie_reg <= 1'b0;
            arm_reg      <= 1'b0;
            arm_cnt_reg  <= 2'h0;
        end else if (clk_en_i) begin
            if (wr_ctrl) begin
                ready_ie_reg <= io_wdata_i[nv_access_pkg::READY_IE_BIT];
            end
            if (arm_set) begin
                arm_reg     <= 1'b1;
                arm_cnt_reg <= nv_access_pkg::ARM_CYCLES;
            end else if (arm_reg) begin
                if (arm_cnt_reg == 2'h0) begin
                    arm_reg <= 1'b0;
                end else begin
                    arm_cnt_reg <= arm_cnt_reg - 2'h1;
                end
            end
        end
    end

    // timing runs on the oscillator tick so the interval tracks its calibration
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            busy_reg   <= 1'b0;
            rc_cnt_reg <= 13'h0000;
        end else if (clk_en_i) begin
            if (wr_go) begin
                busy_reg   <= 1'b1;
                rc_cnt_reg <= 13'h0000;
            end else if (abort || rc_last) begin
                busy_reg <= 1'b0;
            end else if (busy_reg && rc_tick_i) begin
                rc_cnt_reg <= rc_cnt_reg + 13'h0001;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stall_reg <= 3'h0;
            rdata_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_go) begin
                stall_reg <= nv_access_pkg::READ_STALL;
            end else if (wr_go) begin
                stall_reg <= nv_access_pkg::WRITE_STALL;
            end else if (stall_reg != 3'h0) begin
                stall_reg <= stall_reg - 3'h1;
            end
            if (io_rd_i) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    property p_arm_timeout;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && arm_set) ##1 (clk_en_i && !arm_set) [*4] |=> !arm_reg;
    endproperty
    a_arm_timeout: assert property (p_arm_timeout) else $error("arm did not time out");

    property p_arm_hold;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && arm_set) ##1 clk_en_i [*4] |-> arm_reg;
    endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("arm cleared early");

    property p_strobe_starts;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && wr_go && !rc_last) |=> busy_reg;
    endproperty
    a_strobe_starts: assert property (p_strobe_starts) else $error("write not started");

    property p_write_lands;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && wr_go) |=> mem[$past(addr_reg)] == $past(data_reg);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("byte not stored");

    property p_busy_hold;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && busy_reg && !abort && !rc_last) |=> busy_reg;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_no_arm_no_write;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && !busy_reg && !arm_reg) |=> !busy_reg;
    endproperty
    a_no_arm_no_write: assert property (p_no_arm_no_write) else $error("unarmed write");

    property p_irq;
        @(posedge mclk_i) disable iff (sys_rst_i)
        ready_irq_o == (ready_ie_reg && global_irq_en_i && !busy_reg);
    endproperty
    a_irq: assert property (p_irq) else $error("ready request wrong");

    property p_write_stall;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && wr_go) ##1 (clk_en_i && !rd_go && !wr_go) [*2] |->
            cpu_stall_o ##1 !cpu_stall_o;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall length");

    property p_read_stall;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && rd_go) ##1 (clk_en_i && !rd_go && !wr_go) [*4] |->
            cpu_stall_o ##1 !cpu_stall_o;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall length");

    property p_read_fetch;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && rd_go) |=> data_reg == $past(mem[addr_reg]);
    endproperty
    a_read_fetch: assert property (p_read_fetch) else $error("read data wrong");

    property p_abort;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && abort && !wr_go) |=> !busy_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("write not aborted");

    property p_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && io_rd_i && io_addr_i == nv_access_pkg::ADDR_OFS) |=>
            io_rdata_o[7:6] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_ctrl_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clk_en_i && io_rd_i && io_addr_i == nv_access_pkg::CTRL_OFS) |=>
            io_rdata_o[7:4] == 4'h0 && !io_rdata_o[0];
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control bits set");
endmodule : eeprom_byte_access_control
`default_nettype wire

// file: tb/rc_tick_model.sv
`timescale 1ns/1ps
`default_nettype none
module rc_tick_model (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    output logic      rc_tick_o
);
    // half rate: a tick on every other cpu cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rc_tick_o <= 1'b0;
        end else begin
            rc_tick_o <= ~rc_tick_o;
        end
    end
endmodule : rc_tick_model
`default_nettype wire

// file: tb/test_eeprom_byte_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_byte_access_control;
    localparam logic [5:0] AO = nv_access_pkg::ADDR_OFS;
    localparam logic [5:0] DO = nv_access_pkg::DATA_OFS;
    localparam logic [5:0] CO = nv_access_pkg::CTRL_OFS;
    logic       mclk_i = 0, sys_rst_i = 1, gie = 0, io_wr = 0, io_rd = 0, rd_d = 0, clk_en = 1;
    logic       rc_tick, stall, irq;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, rdata, byte_v, addr_v;
    logic [7:0] exp_q[$];
    int         fail_count = 0, comparisons = 0, seed = 32'h2e62, n;
    rc_tick_model model_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rc_tick_o(rc_tick));
    eeprom_byte_access_control dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .rc_tick_i(rc_tick), .global_irq_en_i(gie), .io_addr_i(io_addr), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(rdata), .cpu_stall_o(stall),
        .ready_irq_o(irq));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // read data is registered, so compare one edge after the take
    always @(posedge mclk_i) begin
        rd_d <= io_rd;
        if (rd_d && exp_q.size() > 0) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    task automatic io(input logic [5:0] a, input logic [7:0] d, input logic rd);
        @(posedge mclk_i);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= ~rd;
        io_rd <= rd;
        @(posedge mclk_i);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask : io
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        io(a, 8'h00, 1'b1);
    endtask : rd
    // also serves as the wait-out of the stall window
    task automatic stalls(input logic [7:0] e);
        n = 0;
        repeat (8) begin
            @(posedge mclk_i);
            n += int'(stall === 1'b1);
        end
        chk(8'(n), e);
    endtask : stalls
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rd(CO, 8'h00);
        io(AO, 8'hff, 1'b0);
        rd(AO, 8'h3f);
        io(CO, 8'hf2, 1'b0);
        rd(CO, 8'h00);
        io(CO, 8'h04, 1'b0);
        rd(CO, 8'h04);
        repeat (6) @(posedge mclk_i);
        rd(CO, 8'h00);
        // frozen clock enable: arm must outlive its four cycles
        io(CO, 8'h04, 1'b0);
        clk_en <= 1'b0;
        repeat (6) @(posedge mclk_i);
        clk_en <= 1'b1;
        rd(CO, 8'h04);
        byte_v = 8'($random(seed));
        addr_v = 8'($random(seed)) & 8'h3f;
        io(AO, addr_v, 1'b0);
        io(DO, byte_v, 1'b0);
        io(CO, 8'h0c, 1'b0);
        io(CO, 8'h0e, 1'b0);
        gie <= 1'b1;
        stalls(8'h02);
        rd(CO, 8'h0a);
        chk(8'(irq), 8'h00);
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge mclk_i);
            n++;
        end
        // 8192 half-rate ticks from the strobe, less the edges already spent
        chk(8'(n > 16373 && n < 16376), 8'h01);
        rd(CO, 8'h08);
        io(DO, 8'h00, 1'b0);
        io(CO, 8'h09, 1'b0);
        stalls(8'h04);
        rd(DO, byte_v);
        rd(CO, 8'h08);
        io(CO, 8'h04, 1'b0);
        io(CO, 8'h06, 1'b0);
        stalls(8'h02);
        rd(CO, 8'h02);
        io(DO, 8'h55, 1'b0);
        rd(CO, 8'h00);
        rd(DO, 8'h55);
        io(CO, 8'h08, 1'b0);
        @(posedge mclk_i);
        chk(8'(irq), 8'h01);
        gie <= 1'b0;
        @(posedge mclk_i);
        chk(8'(irq), 8'h00);
        repeat (2) @(posedge mclk_i);
        report_and_stop();
    end
    initial begin
        #(40000 * 10);
        fail_count++;
        report_and_stop();
    end
endmodule : test_eeprom_byte_access_control
`default_nettype wire
